// *** logic/osw_defs.vh ***
// Operation
// - clock monitor failure sets the clock-fail flag, bit 3; software reads and clears it
// - switch request bit reads zero once the requested switch has completed
// - unimplemented bits read zero: control bits 2-1, trim bits 15-6
// - control register writes are taken only after the unlock sequence
// - control and trim registers reset only on power-on reset
// - trim is signed steps: +1 raises 0.375%, -1 lowers 0.375%
// - trim code 100001 lowers about 11.6%, most negative about 12%
`ifndef OSW_DEFS_VH
`define OSW_DEFS_VH

`define OSW_ADR_CTRL        8'h00
`define OSW_ADR_TRIM        8'h04
`define OSW_ADR_UNLOCK      8'h08
`define OSW_ADR_HI          7:2

`define OSW_KEY1            8'h5A
`define OSW_KEY2            8'hA5
`define OSW_FLD_KEY         7:0

`define OSW_BIT_REQ         0
`define OSW_BIT_CF          3
`define OSW_BIT_UNLK        7
`define OSW_FLD_NEW         10:8
`define OSW_FLD_CUR         14:12
`define OSW_FLD_TRIM        5:0
`define OSW_TRIM_MSB        5
`define OSW_TRIM_EXT        10

`define OSW_SRC_FRC         3'h0
`define OSW_SRC_INTERNAL_RC_WITH_PLL      3'h1
`define OSW_SRC_PRI         3'h2
`define OSW_SRC_PRIPLL      3'h3
`define OSW_SRC_RESET       3'h0
`define OSW_TRIM_RESET      6'h00

`define OSW_TRIM_STEP_MPCT  16'h0177
`define OSW_CLK_NS          20
`define OSW_SETTLE_NS       1000
`define OSW_SETTLE_CYC      ((`OSW_SETTLE_NS + `OSW_CLK_NS - 1) / `OSW_CLK_NS)

`endif

// *** logic/osw_switch_seq.v ***
`default_nettype none
`include "osw_defs.vh"
module osw_switch_seq #(
  parameter SETTLE = `OSW_SETTLE_CYC
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       go,
  input  wire [2:0] target,
  input  wire       ready,
  output wire       busy,
  output reg        done_ff,
  output reg        start_en_ff,
  output reg  [2:0] start_sel_ff,
  output reg  [2:0] clk_sel_ff
);
  localparam S_IDLE   = 4'h1;
  localparam S_WAIT   = 4'h2;
  localparam S_SETTLE = 4'h4;
  localparam S_SWAP   = 4'h8;
  localparam CW       = 16;
  localparam [CW-1:0] SETTLE_C = SETTLE[CW-1:0];

  reg [3:0]    state_ff;
  reg [CW-1:0] cnt_ff;

  assign busy = (state_ff != S_IDLE);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= S_IDLE;
      cnt_ff       <= {CW{1'b0}};
      done_ff      <= 1'b0;
      start_en_ff  <= 1'b0;
      start_sel_ff <= `OSW_SRC_RESET;
      clk_sel_ff   <= `OSW_SRC_RESET;
    end
    else
    begin
      done_ff <= 1'b0;
      case (state_ff)
        S_IDLE:
        begin
          if (go)
          begin
            start_sel_ff <= target;
            start_en_ff  <= 1'b1;
            state_ff     <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          // old clock keeps running until the new one proves itself
          if (ready)
          begin
            cnt_ff   <= SETTLE_C;
            state_ff <= S_SETTLE;
          end
        end
        S_SETTLE:
        begin
          if (!ready)
            state_ff <= S_WAIT;
          else if (cnt_ff <= {{(CW-1){1'b0}}, 1'b1})
            state_ff <= S_SWAP;
          else
            cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
        end
        S_SWAP:
        begin
          clk_sel_ff  <= start_sel_ff;
          start_en_ff <= 1'b0;
          done_ff     <= 1'b1;
          state_ff    <= S_IDLE;
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // osw_switch_seq
`default_nettype wire

// *** logic/osw_sync2.v ***
`default_nettype none
module osw_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_ff
);
  reg [W-1:0] meta_ff;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
endmodule // osw_sync2
`default_nettype wire

// *** logic/osw_top.v ***
`default_nettype none
`include "osw_defs.vh"
module osw_top #(
  parameter SETTLE = `OSW_SETTLE_CYC
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        other_rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        failsafe_clock_monitor_fail,
  input  wire        new_src_ready,
  output wire        new_src_start,
  output wire [2:0]  new_src_sel,
  output wire [2:0]  sys_clk_sel,
  output reg  [5:0]  rc_trim_field,
  output reg  [15:0] rc_trim_offset_mpct,
  output reg         clock_fail_flag,
  output wire        switch_busy
);
  // power-on reset release
  reg rst_meta_ff;
  reg rst_ff;

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_ff <= 1'b0;
      rst_ff      <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_ff      <= rst_meta_ff;
    end
  end

  // pin inputs
  wire [2:0] pins_sync;

  osw_sync2 #(
    .W (3)
  ) u_sync (
    .clk      (sys_clk),
    .rst_n    (rst_ff),
    .async_in ({other_rst_n, new_src_ready, failsafe_clock_monitor_fail}),
    .sync_ff  (pins_sync)
  );

  wire fail_s      = pins_sync[0];
  wire ready_s     = pins_sync[1];
  wire other_rst_s = pins_sync[2];

  reg fail_d_ff;

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
      fail_d_ff <= 1'b0;
    else
      fail_d_ff <= fail_s;
  end

  wire fail_evt = fail_s & ~fail_d_ff;

  // bus decode
  localparam [7:0] ADR_CTRL   = `OSW_ADR_CTRL;
  localparam [7:0] ADR_TRIM   = `OSW_ADR_TRIM;
  localparam [7:0] ADR_UNLOCK = `OSW_ADR_UNLOCK;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr  = bus_req & wb_we_i;
  wire hit_ctrl   = (wb_adr_i[`OSW_ADR_HI] == ADR_CTRL[`OSW_ADR_HI]);
  wire hit_trim   = (wb_adr_i[`OSW_ADR_HI] == ADR_TRIM[`OSW_ADR_HI]);
  wire hit_unlock = (wb_adr_i[`OSW_ADR_HI] == ADR_UNLOCK[`OSW_ADR_HI]);

  // unlock sequence
  reg key1_ff;
  reg unlocked_ff;
  wire wr_unlock = bus_wr & hit_unlock & wb_sel_i[0];
  wire wr_ctrl   = bus_wr & hit_ctrl;
  wire ctrl_ok   = wr_ctrl & unlocked_ff;
  wire key1_hit  = (wb_dat_i[`OSW_FLD_KEY] == `OSW_KEY1);
  wire key2_hit  = (wb_dat_i[`OSW_FLD_KEY] == `OSW_KEY2);
  reg  nxt_key1;
  reg  nxt_unlocked;

  // any other write between the keys, or after them, cancels the unlock
  always @*
  begin
    nxt_key1     = key1_ff;
    nxt_unlocked = unlocked_ff;
    if (!other_rst_s)
    begin
      // a non power-on reset only drops a pending unlock
      nxt_key1     = 1'b0;
      nxt_unlocked = 1'b0;
    end
    else if (bus_wr)
    begin
      nxt_key1     = wr_unlock & key1_hit;
      nxt_unlocked = wr_unlock & key1_ff & key2_hit;
    end
  end

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      key1_ff     <= 1'b0;
      unlocked_ff <= 1'b0;
    end
    else
    begin
      key1_ff     <= nxt_key1;
      unlocked_ff <= nxt_unlocked;
    end
  end

  // oscillator control fields
  reg  [2:0] new_src_ff;
  reg        req_ff;
  wire       seq_done;
  wire [2:0] cur_src;

  wire [2:0] wr_new = wb_sel_i[1] ? wb_dat_i[`OSW_FLD_NEW] : new_src_ff;
  wire       wr_req = wb_sel_i[0] & wb_dat_i[`OSW_BIT_REQ];

  wire cur_pll_pri = (cur_src == `OSW_SRC_PRIPLL);
  wire cur_pll_frc = (cur_src == `OSW_SRC_INTERNAL_RC_WITH_PLL);
  wire tgt_pll_pri = (wr_new == `OSW_SRC_PRIPLL);
  wire tgt_pll_frc = (wr_new == `OSW_SRC_INTERNAL_RC_WITH_PLL);
  // pll-to-pll needs a hop through a non-pll source in between; a direct request is dropped
  wire illegal_sw = (cur_pll_pri & tgt_pll_frc) | (cur_pll_frc & tgt_pll_pri);

  wire start_sw = ctrl_ok & wr_req & ~req_ff & ~switch_busy & ~illegal_sw;
  reg  [2:0] nxt_new_src;
  reg        nxt_req;

  // the selection stays frozen while a request is pending
  always @*
  begin
    nxt_new_src = new_src_ff;
    nxt_req     = req_ff;
    if (ctrl_ok && !req_ff)
      nxt_new_src = wr_new;
    if (start_sw)
      nxt_req = 1'b1;
    else if (seq_done)
      nxt_req = 1'b0;
  end

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      new_src_ff <= `OSW_SRC_RESET;
      req_ff     <= 1'b0;
    end
    else
    begin
      new_src_ff <= nxt_new_src;
      req_ff     <= nxt_req;
    end
  end

  // clock fail flag: a new failure wins over a clear in the same cycle
  wire cf_clear = ctrl_ok & wb_sel_i[0] & ~wb_dat_i[`OSW_BIT_CF];
  reg  nxt_clock_fail;

  always @*
  begin
    nxt_clock_fail = clock_fail_flag;
    if (fail_evt)
      nxt_clock_fail = 1'b1;
    else if (cf_clear)
      nxt_clock_fail = 1'b0;
  end

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
      clock_fail_flag <= 1'b0;
    else
      clock_fail_flag <= nxt_clock_fail;
  end

  // switch sequencer
  osw_switch_seq #(
    .SETTLE (SETTLE)
  ) u_seq (
    .clk          (sys_clk),
    .rst_n        (rst_ff),
    .go           (start_sw),
    .target       (wr_new),
    .ready        (ready_s),
    .busy         (switch_busy),
    .done_ff      (seq_done),
    .start_en_ff  (new_src_start),
    .start_sel_ff (new_src_sel),
    .clk_sel_ff   (cur_src)
  );

  assign sys_clk_sel = cur_src;

  // trim register
  wire      wr_trim = bus_wr & hit_trim & wb_sel_i[0];
  reg [5:0] nxt_trim;

  always @*
  begin
    nxt_trim = rc_trim_field;
    if (wr_trim)
      nxt_trim = wb_dat_i[`OSW_FLD_TRIM];
  end

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
      rc_trim_field <= `OSW_TRIM_RESET;
    else
      rc_trim_field <= nxt_trim;
  end

  // signed steps of 0.375 percent, in thousandths of a percent
  // the low half of the product is already the signed result
  wire [15:0] trim_ext   = {{`OSW_TRIM_EXT{rc_trim_field[`OSW_TRIM_MSB]}}, rc_trim_field};
  wire [15:0] nxt_offset = trim_ext * `OSW_TRIM_STEP_MPCT;

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
      rc_trim_offset_mpct <= 16'h0000;
    else
      rc_trim_offset_mpct <= nxt_offset;
  end

  // read mux
  reg [31:0] ctrl_rd;
  reg [31:0] trim_rd;
  reg [31:0] rd_data;

  always @*
  begin
    ctrl_rd                = 32'h0000_0000;
    ctrl_rd[`OSW_BIT_REQ]  = req_ff;
    ctrl_rd[`OSW_BIT_CF]   = clock_fail_flag;
    ctrl_rd[`OSW_BIT_UNLK] = unlocked_ff;
    ctrl_rd[`OSW_FLD_NEW]  = new_src_ff;
    ctrl_rd[`OSW_FLD_CUR]  = cur_src;
  end

  always @*
  begin
    trim_rd                = 32'h0000_0000;
    trim_rd[`OSW_FLD_TRIM] = rc_trim_field;
  end

  always @*
  begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl)
      rd_data = ctrl_rd;
    else if (hit_trim)
      rd_data = trim_rd;
  end

  // wishbone answer: one wait state, unmapped reads zero
  reg        nxt_ack;
  reg [31:0] nxt_dat;

  always @*
  begin
    nxt_ack = bus_req;
    nxt_dat = wb_dat_o;
    // read data stands until the next read
    if (bus_req && !wb_we_i)
      nxt_dat = rd_data;
  end

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= nxt_ack;
  end

  always @(posedge sys_clk or negedge rst_ff)
  begin
    if (!rst_ff)
      wb_dat_o <= 32'h0000_0000;
    else
      wb_dat_o <= nxt_dat;
  end
endmodule // osw_top
`default_nettype wire

// *** tb/osw_chk.sv ***
`default_nettype none
module osw_chk #(
  parameter int SETTLE = 2
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        failsafe_clock_monitor_fail,
  input wire logic        new_src_ready,
  input wire logic        new_src_start,
  input wire logic [2:0]  sys_clk_sel,
  input wire logic [5:0]  rc_trim_field,
  input wire logic [15:0] rc_trim_offset_mpct,
  input wire logic        clock_fail_flag,
  input wire logic        switch_busy
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ctrl_read: assert property (s_rd(8'h00) |-> wb_dat_o[31:15] == 17'h0
    && wb_dat_o[14:12] == sys_clk_sel && wb_dat_o[3] == clock_fail_flag && wb_dat_o[2:1] == 2'b00)
    else $error("bad control read");
  a_trim_read: assert property (s_rd(8'h04) |-> wb_dat_o == {26'h0, rc_trim_field})
    else $error("bad trim read");
  a_trim_offset: assert property (
    rc_trim_offset_mpct == 16'($signed($past(rc_trim_field)) * 16'sd375))
    else $error("trim offset wrong");
  a_sel_hold: assert property (!switch_busy |=> $stable(sys_clk_sel))
    else $error("source moved while idle");
  a_sel_ready: assert property ($changed(sys_clk_sel)
    |-> $past(new_src_ready, 3) && $past(new_src_start))
    else $error("source moved before new one ran");
  a_start_busy: assert property ($rose(new_src_start) |-> switch_busy)
    else $error("start without busy");
  a_fail_flag: assert property ($rose(failsafe_clock_monitor_fail) |-> ##[1:5] clock_fail_flag)
    else $error("fail flag not set");
endmodule // osw_chk

bind osw_top osw_chk #(.SETTLE(SETTLE)) chk_u (.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .failsafe_clock_monitor_fail, .new_src_ready, .new_src_start,
  .sys_clk_sel, .rc_trim_field, .rc_trim_offset_mpct, .clock_fail_flag, .switch_busy);
`default_nettype wire

// *** tb/osw_tb_top.sv ***
`default_nettype none
module osw_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, rstn = 1'b0, other_rst_n = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        failsafe_clock_monitor_fail = 1'b0, new_src_ready = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, xs = 32'h0000_3A38, q, d;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, new_src_start, clock_fail_flag, switch_busy;
  wire  [2:0]  new_src_sel, sys_clk_sel;
  wire  [5:0]  rc_trim_field;
  wire  [15:0] rc_trim_offset_mpct;
  logic [2:0]  c, s;
  int          err_total = 0, n_tests = 0, i;
  logic [2:0]  sq [6] = '{3'h2, 3'h3, 3'h1, 3'h0, 3'h1, 3'h3};
  logic [5:0]  cn [4] = '{6'h01, 6'h3F, 6'h21, 6'h20};

  always #10 sys_clk = ~sys_clk;

  osw_top #(.SETTLE(2)) dut_u (.sys_clk, .rstn, .other_rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .failsafe_clock_monitor_fail,
    .new_src_ready, .new_src_start, .new_src_sel, .sys_clk_sel, .rc_trim_field,
    .rc_trim_offset_mpct, .clock_fail_flag, .switch_busy);

  function automatic logic [31:0] nx();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  function automatic logic [31:0] ctl(logic [2:0] cu, logic [2:0] nw, logic rq, logic cf);
    return {17'h0, cu, 1'b0, nw, 4'h0, cf, 2'b00, rq};
  endfunction
  // a direct hop between the two pll modes is dropped
  function automatic logic ok(logic [2:0] cu, logic [2:0] nw);
    return !((cu == 3'h3 && nw == 3'h1) || (cu == 3'h1 && nw == 3'h3));
  endfunction
  // trim offset in thousandths of a percent, signed, cut to 16 bits with sign fill
  function automatic logic [15:0] offs(logic [5:0] t);
    return 16'($signed(t) * 375);
  endfunction
  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic lim(int n);
    if (n >= 99)
    begin
      err_total++;
      $display("ERROR %0t wait timed out", $time);
      end_of_test();
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] dv);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dv;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 99);
    lim(n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    wb(1'b0, a, nx());
    chk(q, e);
  endtask
  task automatic wc(logic [31:0] dv);
    wb(1'b1, 8'h08, 32'h5A);
    wb(1'b1, 8'h08, 32'hA5);
    wb(1'b1, 8'h00, dv);
  endtask
  // ready held until busy drops, like a slow source settling
  task automatic wt();
    int n;
    n = 0;
    @(posedge sys_clk);
    new_src_ready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (switch_busy !== 1'b0 && n < 99);
    lim(n);
    new_src_ready <= 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      d = nx();
      if (i < 4)
        d[5:0] = cn[i];
      wb(1'b1, 8'h04, d);
      rd(8'h04, {26'h0, d[5:0]});
      chk(32'(rc_trim_offset_mpct), 32'(offs(d[5:0])));
    end
    wb(1'b1, 8'h08, 32'h5A);
    wb(1'b1, 8'h04, 32'h15);
    wb(1'b1, 8'h00, 32'h201);
    rd(8'h00, 32'h0);
    c = 3'h0;
    for (i = 0; i < 6; i++)
    begin
      s = sq[i];
      wc({21'h0, s, 8'h01});
      rd(8'h00, ctl(c, s, ok(c, s), 1'b0));
      chk(32'({new_src_start, switch_busy}), 32'({ok(c, s), ok(c, s)}));
      if (ok(c, s))
        chk(32'(new_src_sel), 32'(s));
      wt();
      if (ok(c, s))
        c = s;
      rd(8'h00, ctl(c, s, 1'b0, 1'b0));
      chk(32'(sys_clk_sel), 32'(c));
      chk(32'({new_src_start, switch_busy}), 32'h0000_0000);
    end
    failsafe_clock_monitor_fail <= 1'b1;
    repeat (8) @(posedge sys_clk);
    failsafe_clock_monitor_fail <= 1'b0;
    rd(8'h00, ctl(c, s, 1'b0, 1'b1));
    wc({21'h0, s, 8'h00});
    rd(8'h00, ctl(c, s, 1'b0, 1'b0));
    other_rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    other_rst_n <= 1'b1;
    rd(8'h04, 32'h15);
    rd(8'h00, ctl(c, s, 1'b0, 1'b0));
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h04, 32'h0);
    rd(8'h00, 32'h0);
    end_of_test();
  end
endmodule // osw_tb_top
`default_nettype wire
